// ### hw/wakeup_measure_regs.svh
`ifndef WAKEUP_MEASURE_REGS_SVH
`define WAKEUP_MEASURE_REGS_SVH

// register indices, byte address is four times the index
`define IDX_PHASE_CFG     10'h036
`define IDX_PHASE_BASE    10'h037
`define IDX_PHASE_AVG     10'h038
`define IDX_PHASE_RESULT  10'h039
`define IDX_CAP_CFG       10'h03a
`define IDX_CAP_BASE      10'h03b
`define IDX_CAP_AVG       10'h03c
`define IDX_CAP_RESULT    10'h03d
`define IDX_CHIP_ID       10'h03f
`define IDX_IRQ_STATUS    10'h040
`define IDX_IRQ_CLEAR     10'h041
`define IDX_IRQ_ENABLE    10'h042
`define IDX_COMMAND       10'h043

// configuration field positions
`define CFG_THR_HI        7
`define CFG_THR_LO        4
`define CFG_INCL_BIT      3
`define CFG_WSEL_HI       2
`define CFG_WSEL_LO       1
`define CFG_BASE_SEL_BIT  0

// event bits of status, clear and enable
`define EVT_PHASE_BIT     0
`define EVT_CAP_BIT       1

// command bits
`define CMD_SET_DEFAULT_BIT 0

// reset values
`define CFG_RST           8'h00
`define VIEW_RST          8'h00
`define EVT_RST           2'h0

// smallest averaging weight is 1/4, a shift of two
`define WEIGHT_SHIFT_BASE 4'h2

`endif

// ### hw/wakeup_measure_pkg.sv
package wakeup_measure_pkg;

	// one configuration byte, same layout for phase and capacitance
	typedef struct packed {
		logic [3:0] delta_threshold;     // trigger distance
		logic       avg_include_trigger; // keep triggering result in average
		logic [1:0] avg_weight_sel;      // 4, 8, 16, 32
		logic       use_average_as_base; // compare against average
	} meas_cfg_t;

	// a result handed over by a measurement engine
	typedef struct packed {
		logic       valid;
		logic [7:0] value;
	} meas_t;

	// registers of one measurement channel
	typedef struct packed {
		meas_cfg_t  cfg;
		logic [7:0] base_value;
		logic [7:0] average_value;
		logic [7:0] result_value;
	} channel_t;

	// the whole state of the bank
	typedef struct packed {
		channel_t    phase;
		channel_t    cap;
		logic [1:0]  status;
		logic [1:0]  enable;
		logic [31:0] rdata;
		logic        slverr;
	} state_t;

endpackage

// ### hw/wakeup_measure_regs.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// What this block does
// - config bits 7:4 hold trigger threshold
// - config bit 3 includes triggering result in average
// - weight code 00..11 gives 4, 8, 16, 32
// - config bit 0 selects average as base
// - base registers read-write, cleared by default
// - capacitance config read-write, cleared by default
// - average views read-only, cleared by default
// - result views read-only, cleared by default
// - views ignore writes, zero until measured
// - identity: type bits 7:3, revision 2:0
// - phase config shares the capacitance layout
`include "wakeup_measure_regs.svh"

module wakeup_measure_regs
	import wakeup_measure_pkg::*;
#(
	parameter logic [4:0] CHIP_TYPE = 5'h1e, // arbitrary value
	parameter logic [2:0] SILICON_REV = 3'h7 // arbitrary value
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire meas_t       phase_meas,
	input  wire meas_t       cap_meas,
	output logic             irq
);

	state_t st_reg;  // all state
	state_t st_next; // its next value

	// distance between two unsigned bytes
	function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
		if (a > b) begin
			abs_diff = a - b;
		end else begin
			abs_diff = b - a;
		end
	endfunction

	// reference the new result is compared against
	function automatic logic [7:0] base_of(input channel_t c);
		if (c.cfg.use_average_as_base) begin
			base_of = c.average_value;
		end else begin
			base_of = c.base_value;
		end
	endfunction

	// does a result trip the wake-up threshold
	function automatic logic trips(input channel_t c, input logic [7:0] v);
		trips = abs_diff(v, base_of(c)) > {4'h0, c.cfg.delta_threshold};
	endfunction

	// one averaging step; the arithmetic shift never overshoots the result
	function automatic logic [7:0] avg_step(input logic [7:0] avg, input logic [7:0] v,
		input logic [1:0] wsel);
		logic signed [9:0] d;
		logic signed [9:0] s;
		logic [3:0]        sh;
		d = $signed({2'b00, v}) - $signed({2'b00, avg});
		sh = `WEIGHT_SHIFT_BASE + {2'b00, wsel};
		s = d >>> sh;
		avg_step = 8'(10'($signed({2'b00, avg}) + s));
	endfunction

	// next state of a channel after a measurement
	function automatic channel_t chan_update(input channel_t c, input meas_t m);
		channel_t r;
		logic     t;
		r = c;
		t = trips(c, m.value);
		if (m.valid) begin
			r.result_value = m.value;
			// a tripping result may be kept out of the average
			if (!t || c.cfg.avg_include_trigger) begin
				r.average_value = avg_step(c.average_value, m.value, c.cfg.avg_weight_sel);
			end
		end
		chan_update = r;
	endfunction

	// default contents of a channel
	function automatic channel_t chan_default();
		channel_t r;
		r.cfg = meas_cfg_t'(`CFG_RST);
		r.base_value = `VIEW_RST;
		r.average_value = `VIEW_RST;
		r.result_value = `VIEW_RST;
		chan_default = r;
	endfunction

	logic [9:0] idx;       // word index of the access
	logic       setup;     // first cycle of a transfer
	logic       wr;        // write takes effect now
	logic [1:0] evt;       // events of this cycle
	logic [1:0] clr;       // software clear of this cycle
	logic       set_dflt;  // set-default command

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	// lane 0 carries every register; other lanes are ignored
	assign wr = psel && penable && pwrite && pstrb[0];
	assign evt[`EVT_PHASE_BIT] = phase_meas.valid && trips(st_reg.phase, phase_meas.value);
	assign evt[`EVT_CAP_BIT] = cap_meas.valid && trips(st_reg.cap, cap_meas.value);
	assign clr = (wr && idx == `IDX_IRQ_CLEAR) ? pwdata[1:0] : 2'h0;
	assign set_dflt = wr && idx == `IDX_COMMAND && pwdata[`CMD_SET_DEFAULT_BIT];

	// read data is fetched in setup, so the access needs no wait state
	assign pready = 1'b1;
	assign prdata = st_reg.rdata;
	assign pslverr = st_reg.slverr;
	// level output, follows the enabled sticky bits
	assign irq = |(st_reg.status & st_reg.enable);

	// next-state logic
	always_comb begin
		st_next = st_reg;
		// measurements first
		st_next.phase = chan_update(st_reg.phase, phase_meas);
		st_next.cap = chan_update(st_reg.cap, cap_meas);
		// sticky events: a set in the clear cycle wins
		st_next.status = (st_reg.status & ~clr) | evt;
		// read fetch and error in setup
		if (setup) begin
			st_next.rdata = 32'h0;
			st_next.slverr = 1'b0;
			if (idx == `IDX_PHASE_CFG) begin
				st_next.rdata[7:0] = st_reg.phase.cfg;
			end else if (idx == `IDX_PHASE_BASE) begin
				st_next.rdata[7:0] = st_reg.phase.base_value;
			end else if (idx == `IDX_PHASE_AVG) begin
				st_next.rdata[7:0] = st_reg.phase.average_value;
			end else if (idx == `IDX_PHASE_RESULT) begin
				st_next.rdata[7:0] = st_reg.phase.result_value;
			end else if (idx == `IDX_CAP_CFG) begin
				st_next.rdata[7:0] = st_reg.cap.cfg;
			end else if (idx == `IDX_CAP_BASE) begin
				st_next.rdata[7:0] = st_reg.cap.base_value;
			end else if (idx == `IDX_CAP_AVG) begin
				st_next.rdata[7:0] = st_reg.cap.average_value;
			end else if (idx == `IDX_CAP_RESULT) begin
				st_next.rdata[7:0] = st_reg.cap.result_value;
			end else if (idx == `IDX_CHIP_ID) begin
				st_next.rdata[7:0] = {CHIP_TYPE, SILICON_REV};
			end else if (idx == `IDX_IRQ_STATUS) begin
				st_next.rdata[1:0] = st_reg.status;
			end else if (idx == `IDX_IRQ_ENABLE) begin
				st_next.rdata[1:0] = st_reg.enable;
			end else if (idx == `IDX_IRQ_CLEAR || idx == `IDX_COMMAND) begin
				// write-only, reads as zero
				st_next.rdata = 32'h0;
			end else begin
				// unmapped word
				st_next.slverr = 1'b1;
			end
		end
		// software writes; views and identity are not listed, so ignored
		if (wr) begin
			if (idx == `IDX_PHASE_CFG) begin
				st_next.phase.cfg = meas_cfg_t'(pwdata[7:0]);
			end else if (idx == `IDX_PHASE_BASE) begin
				st_next.phase.base_value = pwdata[7:0];
			end else if (idx == `IDX_CAP_CFG) begin
				st_next.cap.cfg = meas_cfg_t'(pwdata[7:0]);
			end else if (idx == `IDX_CAP_BASE) begin
				st_next.cap.base_value = pwdata[7:0];
			end else if (idx == `IDX_IRQ_ENABLE) begin
				st_next.enable = pwdata[1:0];
			end
		end
		// set-default beats a measurement of the same cycle
		if (set_dflt) begin
			st_next.phase = chan_default();
			st_next.cap = chan_default();
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0; // every field resets to zero
		end else begin
			st_reg <= st_next;
		end
	end

	// base register holds what software wrote
	property p_base_write;
		@(posedge pclk) disable iff (!presetn)
		(wr && idx == `IDX_CAP_BASE && !set_dflt) |=> (st_reg.cap.base_value == $past(pwdata[7:0]));
	endproperty
	a_base_write: assert property (p_base_write) else $error("base write lost");

	// a view is not changed by a software write
	property p_view_ro;
		@(posedge pclk) disable iff (!presetn)
		(wr && idx == `IDX_CAP_RESULT && !cap_meas.valid && !set_dflt) |=> $stable(st_reg.cap);
	endproperty
	a_view_ro: assert property (p_view_ro) else $error("view changed by write");

	// identity read shows type and revision
	property p_identity;
		@(posedge pclk) disable iff (!presetn)
		(setup && idx == `IDX_CHIP_ID) ##1 (psel && penable)
			|-> (prdata == {24'h0, CHIP_TYPE, SILICON_REV}) && !pslverr;
	endproperty
	a_identity: assert property (p_identity) else $error("identity wrong");

	// a tripping capacitance result raises its sticky bit
	property p_cap_event;
		@(posedge pclk) disable iff (!presetn)
		(cap_meas.valid && abs_diff(cap_meas.value, base_of(st_reg.cap))
			> {4'h0, st_reg.cap.cfg.delta_threshold}) |=> st_reg.status[`EVT_CAP_BIT];
	endproperty
	a_cap_event: assert property (p_cap_event) else $error("cap event missed");

	// a result within the threshold raises nothing
	property p_no_event;
		@(posedge pclk) disable iff (!presetn)
		(!st_reg.status[`EVT_CAP_BIT] && !(cap_meas.valid && abs_diff(cap_meas.value,
			base_of(st_reg.cap)) > {4'h0, st_reg.cap.cfg.delta_threshold}))
			|=> !st_reg.status[`EVT_CAP_BIT];
	endproperty
	a_no_event: assert property (p_no_event) else $error("spurious cap event");

	// excluded tripping result leaves the average alone
	property p_exclude;
		@(posedge pclk) disable iff (!presetn)
		(cap_meas.valid && !st_reg.cap.cfg.avg_include_trigger && !set_dflt
			&& trips(st_reg.cap, cap_meas.value)) |=> $stable(st_reg.cap.average_value);
	endproperty
	a_exclude: assert property (p_exclude) else $error("excluded result averaged");

	// weight 32 from zero toward 0x40 gives 2
	property p_weight32;
		@(posedge pclk) disable iff (!presetn)
		(cap_meas.valid && cap_meas.value == 8'h40 && st_reg.cap.average_value == 8'h00
			&& st_reg.cap.cfg.avg_weight_sel == 2'h3 && st_reg.cap.cfg.avg_include_trigger
			&& !set_dflt) |=> (st_reg.cap.average_value == 8'h02);
	endproperty
	a_weight32: assert property (p_weight32) else $error("weight 32 wrong");

	// set-default clears every register of both channels
	property p_default;
		@(posedge pclk) disable iff (!presetn)
		set_dflt |=> (st_reg.cap == '0) && (st_reg.phase == '0);
	endproperty
	a_default: assert property (p_default) else $error("set default incomplete");

	// the result view follows the measurement
	property p_result;
		@(posedge pclk) disable iff (!presetn)
		(phase_meas.valid && !set_dflt) |=> (st_reg.phase.result_value == $past(phase_meas.value));
	endproperty
	a_result: assert property (p_result) else $error("result view stale");

	// interrupt drops after both enable bits are written zero
	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		(wr && idx == `IDX_IRQ_ENABLE && pwdata[1:0] == 2'h0) |=> !irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq while disabled");

endmodule

// ### test/wakeup_measure_regs_tb.sv
`timescale 1ns/1ps
`include "wakeup_measure_regs.svh"

module wakeup_measure_regs_tb
	import wakeup_measure_pkg::*;
;
	localparam logic [4:0] TYPE_CODE = 5'h12; // arbitrary value
	localparam logic [2:0] REV_CODE  = 3'h6;  // arbitrary value

	logic        pclk, presetn, psel, penable, pwrite; // apb controls
	logic [11:0] paddr;                               // byte address
	logic [31:0] pwdata, prdata;                      // data buses
	logic [3:0]  pstrb;                               // byte strobes
	logic        pready, pslverr, irq;                // dut answers
	meas_t       phase_meas, cap_meas;                // result pulses
	logic [7:0]  rd;                                  // last read byte
	logic        er;                                  // last error flag
	int          fails, samples_checked, w, i;

	wakeup_measure_regs #(.CHIP_TYPE(TYPE_CODE), .SILICON_REV(REV_CODE)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phase_meas(phase_meas), .cap_meas(cap_meas), .irq(irq));

	// free running 40 mhz clock
	always #12.5 pclk = ~pclk;

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	// one apb transfer; answer taken at the edge where pready is seen high
	task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// access phase lasts until pready is seen high at a rising edge
		forever begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		// answer taken at that same edge, then the request is released
		rd = prdata[7:0];
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk_data(rd, exp);
	endtask

	// one-cycle result pulse on either channel, irq settled afterwards
	task automatic meas(input logic cap, input logic [7:0] v);
		@(posedge pclk);
		if (cap)
			cap_meas <= '{valid: 1'b1, value: v};
		else
			phase_meas <= '{valid: 1'b1, value: v};
		@(posedge pclk);
		cap_meas.valid   <= 1'b0;
		phase_meas.valid <= 1'b0;
		@(negedge pclk);
	endtask

	// watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#(25 * 20000);
		fails++;
		close_out();
	end

	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = '0; pwdata = '0; pstrb = 4'h1; fails = 0; samples_checked = 0;
		phase_meas = '0; cap_meas = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// every channel register reads zero out of reset
		for (i = 'h36; i <= 'h3d; i++)
			rd_chk(i[9:0], 8'h00);
		rd_chk(`IDX_CHIP_ID, {TYPE_CODE, REV_CODE});
		xfer(1'b0, 10'h03e, 8'h00); // hole in the map
		chk_flag(er, 1'b1);
		chk_data(rd, 8'h00);
		// rw registers keep writes, views drop them (rw iff index bit 1)
		for (i = 'h36; i <= 'h3d; i++)
			xfer(1'b1, i[9:0], 8'h5a);
		for (i = 'h36; i <= 'h3d; i++)
			rd_chk(i[9:0], i[1] ? 8'h5a : 8'h00);
		pstrb <= 4'h0; // strobe off, write must vanish
		xfer(1'b1, `IDX_PHASE_CFG, 8'h11);
		pstrb <= 4'h1;
		rd_chk(`IDX_PHASE_CFG, 8'h5a);
		xfer(1'b1, `IDX_COMMAND, 8'h01);
		for (i = 'h36; i <= 'h3d; i++)
			rd_chk(i[9:0], 8'h00);
		// capacitance: threshold 2, excluded, weight 4, stored base 0x10
		xfer(1'b1, `IDX_IRQ_ENABLE, 8'h03);
		xfer(1'b1, `IDX_CAP_BASE, 8'h10);
		xfer(1'b1, `IDX_CAP_CFG, 8'h20);
		meas(1'b1, 8'h12);
		chk_flag(irq, 1'b0);
		rd_chk(`IDX_CAP_RESULT, 8'h12);
		rd_chk(`IDX_CAP_AVG, 8'h04);
		meas(1'b1, 8'h13);
		chk_flag(irq, 1'b1);
		rd_chk(`IDX_CAP_AVG, 8'h04);
		rd_chk(`IDX_IRQ_STATUS, 8'h02);
		xfer(1'b1, `IDX_IRQ_CLEAR, 8'h02);
		@(negedge pclk); // status settles after the write edge
		chk_flag(irq, 1'b0);
		// masked event still latches status
		xfer(1'b1, `IDX_IRQ_ENABLE, 8'h01);
		meas(1'b1, 8'h13);
		chk_flag(irq, 1'b0);
		rd_chk(`IDX_IRQ_STATUS, 8'h02);
		xfer(1'b1, `IDX_IRQ_ENABLE, 8'h03);
		@(negedge pclk); // enable settles after the write edge
		chk_flag(irq, 1'b1);
		// include bit lets the triggering result into the average
		xfer(1'b1, `IDX_CAP_CFG, 8'h28);
		meas(1'b1, 8'h44);
		rd_chk(`IDX_CAP_AVG, 8'h14);
		// masking every event drops the pending interrupt
		xfer(1'b1, `IDX_IRQ_ENABLE, 8'h00);
		@(negedge pclk);
		chk_flag(irq, 1'b0);
		xfer(1'b1, `IDX_IRQ_ENABLE, 8'h03);
		@(negedge pclk);
		chk_flag(irq, 1'b1);
		xfer(1'b1, `IDX_IRQ_CLEAR, 8'h03);
		// every weight code on the phase channel, from a zero average
		for (w = 0; w < 4; w++) begin
			xfer(1'b1, `IDX_COMMAND, 8'h01);
			xfer(1'b1, `IDX_PHASE_CFG, {4'hf, 1'b1, w[1:0], 1'b0});
			meas(1'b0, 8'h80);
			rd_chk(`IDX_PHASE_AVG, 8'h80 >> (2 + w));
		end
		// capacitance weight 32 from a zero average toward 0x40
		xfer(1'b1, `IDX_CAP_CFG, 8'h0e);
		meas(1'b1, 8'h40);
		rd_chk(`IDX_CAP_AVG, 8'h02);
		// average 4 as base trips, stored base 7 does not
		xfer(1'b1, `IDX_IRQ_CLEAR, 8'h03);
		xfer(1'b1, `IDX_PHASE_BASE, 8'h07);
		xfer(1'b1, `IDX_PHASE_CFG, 8'h11);
		meas(1'b0, 8'h07);
		rd_chk(`IDX_IRQ_STATUS, 8'h01);
		rd_chk(`IDX_PHASE_AVG, 8'h04);
		xfer(1'b1, `IDX_IRQ_CLEAR, 8'h01);
		xfer(1'b1, `IDX_PHASE_CFG, 8'h10);
		meas(1'b0, 8'h07);
		rd_chk(`IDX_IRQ_STATUS, 8'h00);
		chk_flag(irq, 1'b0);
		close_out();
	end
endmodule
